// file: core/dsm_sequencer.sv
`timescale 1ns/1ns
`include "dsm_regs.svh"


module dsm_sequencer
	import dsm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Command sources
	input  wire logic [15:0] network_command_word,
	input  wire logic [15:0] application_command_word,
	input  wire logic [15:0] local_keypad_word,
	input  wire dsm_source_t control_source_select,
	// Drive events
	input  wire logic        init_complete,
	input  wire logic        drive_trip,
	input  wire logic        fault_present,
	input  wire logic        line_supply_present,
	input  wire logic        stop_complete,
	input  wire logic        shutdown_complete,
	input  wire logic        quick_stop_complete,
	input  wire logic        fault_reaction_complete,
	// Read-only words
	output logic      [15:0] effective_command_word,
	output logic      [15:0] sequencer_status_word,
	output logic      [2:0]  sequencing_state,
	// Motor control requests
	output logic             run_enable,
	output logic             jog_select,
	output logic             reverse_select,
	output logic             network_reference_select
);

	// Command classes, decoded from the registered command word
	function automatic logic cmd_disable_voltage(input logic [15:0] w);
		cmd_disable_voltage = ~w[`DSM_CMD_ENABLE_VOLTAGE];
	endfunction

	function automatic logic cmd_quick_stop(input logic [15:0] w);
		cmd_quick_stop = w[`DSM_CMD_ENABLE_VOLTAGE] &
			~w[`DSM_CMD_QS_INACTIVE];
	endfunction

	function automatic logic cmd_shutdown(input logic [15:0] w);
		cmd_shutdown = w[`DSM_CMD_ENABLE_VOLTAGE] &
			w[`DSM_CMD_QS_INACTIVE] &
			(~w[`DSM_CMD_SWITCH_ON] | w[`DSM_CMD_AUTO_INIT]);
	endfunction

	function automatic logic cmd_switch_on(input logic [15:0] w);
		cmd_switch_on = w[`DSM_CMD_ENABLE_VOLTAGE] &
			w[`DSM_CMD_QS_INACTIVE] &
			w[`DSM_CMD_SWITCH_ON];
	endfunction

	dsm_regs_t   regs_reg;
	dsm_regs_t   regs_next;
	logic [15:0] merged_command;
	logic        network_active;
	logic [15:0] cmd;
	logic        trip_level;
	logic        trip_event;
	logic        reset_edge;
	logic        enable_edge;
	logic        enable_ok;
	logic        op_enabled;

	// Source merging kept apart so the state logic sees one word
	dsm_command_select u_select (
		.network_command_word     (network_command_word),
		.application_command_word (application_command_word),
		.local_keypad_word        (local_keypad_word),
		.control_source_select    (control_source_select),
		.merged_command_word      (merged_command),
		.network_source_active    (network_active)
	);

	// Decisions use the registered word; costs one cycle, avoids
	// a long path from the source pins straight into the state flops
	assign cmd = regs_reg.command;

	// External trip joins the drive trip; only a new trip counts
	assign trip_level = drive_trip | cmd[`DSM_CMD_EXT_FAULT];
	assign trip_event = trip_level & ~regs_reg.prev_trip;

	// Fault reset acts on the 0 to 1 transition only
	assign reset_edge = cmd[`DSM_CMD_FAULT_RESET] &
		~regs_reg.prev_fault_reset;

	// Edge-start guards against an unexpected motor start
	assign enable_edge = cmd[`DSM_CMD_ENABLE_OP] &
		~regs_reg.prev_enable_op;
	assign enable_ok = cmd[`DSM_CMD_EDGE_START] ?
		enable_edge : cmd[`DSM_CMD_ENABLE_OP];

	// Next state and next register copy
	always_comb begin
		regs_next = regs_reg;
		regs_next.command = merged_command;
		regs_next.prev_fault_reset = cmd[`DSM_CMD_FAULT_RESET];
		regs_next.prev_enable_op = cmd[`DSM_CMD_ENABLE_OP];
		regs_next.prev_trip = trip_level;

		if (trip_event &&
			regs_reg.state != DSM_FAULT_REACT) begin
			regs_next.state = DSM_FAULT_REACT;
		end else begin
			case (regs_reg.state)
				DSM_NOT_READY: begin
					if (init_complete) begin
						regs_next.state = DSM_SO_DISABLED;
					end
				end
				DSM_SO_DISABLED: begin
					if (cmd_shutdown(cmd)) begin
						regs_next.state = DSM_READY;
					end
				end
				DSM_READY: begin
					if (cmd_disable_voltage(cmd) ||
						cmd_quick_stop(cmd)) begin
						regs_next.state = DSM_SO_DISABLED;
					end else if (cmd_switch_on(cmd)) begin
						regs_next.state = DSM_SWITCHED_ON;
					end
				end
				DSM_SWITCHED_ON: begin
					if (cmd_disable_voltage(cmd) ||
						cmd_quick_stop(cmd)) begin
						regs_next.state = DSM_SO_DISABLED;
					end else if (~cmd[`DSM_CMD_SWITCH_ON]) begin
						regs_next.state = DSM_READY;
					end else if (enable_ok) begin
						regs_next.state = DSM_OP_ENABLED;
					end
				end
				DSM_OP_ENABLED: begin
					if (cmd_disable_voltage(cmd)) begin
						regs_next.state = DSM_SO_DISABLED;
					end else if (cmd_quick_stop(cmd)) begin
						regs_next.state = DSM_QS_ACTIVE;
					end else if (~cmd[`DSM_CMD_SWITCH_ON] &&
						shutdown_complete) begin
						regs_next.state = DSM_READY;
					end else if (~cmd[`DSM_CMD_ENABLE_OP] &&
						stop_complete) begin
						regs_next.state = DSM_SWITCHED_ON;
					end
				end
				DSM_QS_ACTIVE: begin
					if (quick_stop_complete ||
						cmd_disable_voltage(cmd)) begin
						regs_next.state = DSM_SO_DISABLED;
					end
				end
				DSM_FAULT_REACT: begin
					if (fault_reaction_complete ||
						cmd_disable_voltage(cmd)) begin
						regs_next.state = DSM_FAULTED;
					end
				end
				DSM_FAULTED: begin
					if (reset_edge && !fault_present &&
						!trip_level) begin
						regs_next.state = DSM_SO_DISABLED;
					end
				end
				default: begin
					regs_next.state = DSM_NOT_READY;
				end
			endcase
		end

		// Run, jog and reverse follow the next state so they line up; net_ref follows the command bit alone
		op_enabled = (regs_next.state == DSM_OP_ENABLED);
		regs_next.run = op_enabled &
			regs_next.command[`DSM_CMD_ENABLE_OP];
		regs_next.jog = regs_next.run &
			regs_next.command[`DSM_CMD_JOG];
		regs_next.reverse = regs_next.run &
			regs_next.command[`DSM_CMD_REVERSE];
		regs_next.net_ref =
			regs_next.command[`DSM_CMD_NET_REF];

		// Status is rebuilt every cycle whatever the source
		regs_next.status = `DSM_WORD_RESET;
		regs_next.status[`DSM_STS_READY] =
			(regs_next.state == DSM_READY) |
			(regs_next.state == DSM_SWITCHED_ON) |
			op_enabled |
			(regs_next.state == DSM_QS_ACTIVE);
		regs_next.status[`DSM_STS_SWITCHED_ON] =
			(regs_next.state == DSM_SWITCHED_ON) |
			op_enabled;
		regs_next.status[`DSM_STS_OP_ENABLED] =
			op_enabled;
		regs_next.status[`DSM_STS_SO_DISABLED] =
			(regs_next.state == DSM_SO_DISABLED);
		regs_next.status[`DSM_STS_FAULTED] =
			(regs_next.state == DSM_FAULT_REACT) |
			(regs_next.state == DSM_FAULTED);
		regs_next.status[`DSM_STS_VOLTAGE] =
			line_supply_present;
		regs_next.status[`DSM_STS_QS_INACTIVE] =
			(regs_next.state != DSM_QS_ACTIVE);
		regs_next.status[`DSM_STS_STOPPING] =
			(op_enabled &
			 ~regs_next.command[`DSM_CMD_ENABLE_OP]) |
			(regs_next.state == DSM_QS_ACTIVE);
		regs_next.status[`DSM_STS_NET_CONTROL] =
			network_active;
		regs_next.status[`DSM_STS_JOG] =
			regs_next.command[`DSM_CMD_JOG];
		regs_next.status[`DSM_STS_REVERSE] =
			regs_next.command[`DSM_CMD_REVERSE];
		regs_next.status[`DSM_STS_NET_REF] =
			regs_next.command[`DSM_CMD_NET_REF];
		regs_next.status = regs_next.status &
			~`DSM_STS_UNUSED_MASK;
	end

	// Single register bank for all sequencer state
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regs_reg.state <= DSM_NOT_READY;
			regs_reg.command <= `DSM_WORD_RESET;
			regs_reg.status <= `DSM_WORD_RESET;
			regs_reg.prev_fault_reset <= 1'b0;
			regs_reg.prev_enable_op <= 1'b0;
			regs_reg.prev_trip <= 1'b0;
			regs_reg.run <= 1'b0;
			regs_reg.jog <= 1'b0;
			regs_reg.reverse <= 1'b0;
			regs_reg.net_ref <= 1'b0;
		end else begin
			regs_reg <= regs_next;
		end
	end

	// Outputs taken straight from the flops
	assign effective_command_word = regs_reg.command;
	assign sequencer_status_word = regs_reg.status;
	assign sequencing_state = regs_reg.state;
	assign run_enable = regs_reg.run;
	assign jog_select = regs_reg.jog;
	assign reverse_select = regs_reg.reverse;
	assign network_reference_select = regs_reg.net_ref;

endmodule // dsm_sequencer

// file: core/dsm_regs.svh
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

// Command word bit positions
`define DSM_CMD_SWITCH_ON      0
`define DSM_CMD_ENABLE_VOLTAGE 1
`define DSM_CMD_QS_INACTIVE    2
`define DSM_CMD_ENABLE_OP      3
`define DSM_CMD_FAULT_RESET    7
`define DSM_CMD_EXT_FAULT      8
`define DSM_CMD_NET_CONTROL    10
`define DSM_CMD_NET_REF        11
`define DSM_CMD_JOG            12
`define DSM_CMD_REVERSE        13
`define DSM_CMD_AUTO_INIT      14
`define DSM_CMD_EDGE_START     15

// Status word bit positions
`define DSM_STS_READY          0
`define DSM_STS_SWITCHED_ON    1
`define DSM_STS_OP_ENABLED     2
`define DSM_STS_FAULTED        3
`define DSM_STS_VOLTAGE        4
`define DSM_STS_QS_INACTIVE    5
`define DSM_STS_SO_DISABLED    6
`define DSM_STS_NET_CONTROL    9
`define DSM_STS_JOG            12
`define DSM_STS_REVERSE        13
`define DSM_STS_NET_REF        14
`define DSM_STS_STOPPING       15

// Source merge masks, unused bit masks and reset value
`define DSM_NET_AND_MASK       16'h0007
`define DSM_NET_OR_MASK        16'h0100
`define DSM_LOCAL_APP_MASK     16'h0107
`define DSM_CMD_UNUSED_MASK    16'h0200
`define DSM_STS_UNUSED_MASK    16'h0D80
`define DSM_WORD_RESET         16'h0000

`endif

// file: core/dsm_pkg.sv
package dsm_pkg;

	// Sequencing states, values as reported
	typedef enum logic [2:0] {
		DSM_NOT_READY     = 3'b000,
		DSM_SO_DISABLED   = 3'b001,
		DSM_READY         = 3'b010,
		DSM_SWITCHED_ON   = 3'b011,
		DSM_OP_ENABLED    = 3'b100,
		DSM_QS_ACTIVE     = 3'b101,
		DSM_FAULT_REACT   = 3'b110,
		DSM_FAULTED       = 3'b111
	} dsm_state_t;

	// Selectable control source
	typedef enum logic [1:0] {
		DSM_SRC_NETWORK   = 2'b00,
		DSM_SRC_APP       = 2'b01,
		DSM_SRC_LOCAL     = 2'b10
	} dsm_source_t;

	// Whole register state of the sequencer
	typedef struct packed {
		dsm_state_t  state;
		logic [15:0] command;
		logic [15:0] status;
		logic        prev_fault_reset;
		logic        prev_enable_op;
		logic        prev_trip;
		logic        run;
		logic        jog;
		logic        reverse;
		logic        net_ref;
	} dsm_regs_t;

endpackage

// file: core/dsm_command_select.sv
`timescale 1ns/1ns
`include "dsm_regs.svh"

module dsm_command_select
	import dsm_pkg::*;
(
	// Command sources
	input  wire logic [15:0] network_command_word,
	input  wire logic [15:0] application_command_word,
	input  wire logic [15:0] local_keypad_word,
	input  wire dsm_source_t control_source_select,
	// Merged result
	output logic      [15:0] merged_command_word,
	output logic             network_source_active
);

	logic [15:0] net_merged;
	logic [15:0] local_merged;
	logic [15:0] chosen;

	// Network wins when selected or when the application hands over
	assign network_source_active =
		(control_source_select == DSM_SRC_NETWORK) |
		((control_source_select == DSM_SRC_APP) &
		 application_command_word[`DSM_CMD_NET_CONTROL]);

	// Application keeps a veto on the stop bits and can force a trip
	assign net_merged =
		(network_command_word &
		 ~(`DSM_NET_AND_MASK | `DSM_NET_OR_MASK)) |
		(network_command_word & application_command_word &
		 `DSM_NET_AND_MASK) |
		((network_command_word | application_command_word) &
		 `DSM_NET_OR_MASK);

	// Keypad drives the rest, safety bits stay with the application
	assign local_merged =
		(local_keypad_word & ~`DSM_LOCAL_APP_MASK) |
		(application_command_word & `DSM_LOCAL_APP_MASK);

	// Pick the source, unused bit always reads zero
	always_comb begin
		if (control_source_select == DSM_SRC_LOCAL) begin
			chosen = local_merged;
		end else if (network_source_active) begin
			chosen = net_merged;
		end else begin
			chosen = application_command_word;
		end
		merged_command_word = chosen & ~`DSM_CMD_UNUSED_MASK;
	end

endmodule // dsm_command_select

// file: tb/dsm_sequencer_sva.sv
`timescale 1ns/1ns

module dsm_sequencer_sva
	import dsm_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// Sources and events
	input wire logic [15:0] network_command_word,
	input wire logic [15:0] application_command_word,
	input wire logic [15:0] local_keypad_word,
	input wire dsm_source_t control_source_select,
	input wire logic        drive_trip,
	input wire logic        fault_present,
	input wire logic        quick_stop_complete,
	input wire logic        fault_reaction_complete,
	// Watched outputs
	input wire logic [15:0] effective_command_word,
	input wire logic [15:0] sequencer_status_word,
	input wire logic [2:0]  sequencing_state,
	input wire logic        run_enable,
	input wire logic        jog_select,
	input wire logic        reverse_select
);
	logic [15:0] merge_reg;
	logic [15:0] sts;
	logic [2:0]  st;

	assign sts = sequencer_status_word;
	assign st  = sequencing_state;

	// Expected merge, one edge behind the sources like the real word
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			merge_reg <= 16'h0000;
		else if (control_source_select == DSM_SRC_LOCAL)
			merge_reg <= ((local_keypad_word & 16'hFEF8)
				| (application_command_word & 16'h0107)) & 16'hFDFF;
		else if (control_source_select == DSM_SRC_NETWORK
			|| application_command_word[10])
			merge_reg <= ((network_command_word & 16'hFEF8)
				| (network_command_word & application_command_word
				& 16'h0007) | ((network_command_word
				| application_command_word) & 16'h0100)) & 16'hFDFF;
		else
			merge_reg <= application_command_word & 16'hFDFF;
	end

	// All checks share the one clock and reset
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_cmd_merge: assert property (effective_command_word == merge_reg)
		else $error("command word merge wrong");
	a_unused_zero: assert property (!effective_command_word[9]
		&& (sts & 16'h0D80) == 16'h0000) else $error("unused bit set");
	a_trip_reacts: assert property ($rose(drive_trip) && st != 3'd6
		|=> st == 3'd6) else $error("trip not taken");
	a_fault_hold: assert property (st == 3'd7 && (fault_present
		|| drive_trip) |=> st inside {3'd6, 3'd7}) else $error("left fault");
	a_state_status: assert property (sts[6] == (st == 3'd1)
		&& sts[2] == (st == 3'd4) && sts[1] == (st inside {3'd3, 3'd4}))
		else $error("status state bits wrong");
	a_fault_status: assert property (sts[3] == (st >= 3'd6))
		else $error("fault status bit wrong");
	a_qs_status: assert property (st == 3'd5 |-> !sts[5] && sts[15])
		else $error("quick stop status wrong");
	a_run_gate: assert property ((jog_select || reverse_select
		|-> run_enable) and (run_enable |-> st == 3'd4))
		else $error("run outside enabled");
	a_qs_leave: assert property (st == 3'd5 && quick_stop_complete
		&& !drive_trip |=> st == 3'd1) else $error("quick stop stuck");
	a_react_done: assert property (st == 3'd6 && fault_reaction_complete
		|=> st == 3'd7) else $error("fault reaction stuck");

	// Main scenarios reached
	c_enabled: cover property (st == 3'd4);
	c_quick: cover property (st == 3'd5);
	c_reset_fault: cover property (st == 3'd7 ##1 st == 3'd1);
endmodule // dsm_sequencer_sva

// file: tb/dsm_commander.sv
`timescale 1ns/1ns

module dsm_commander (
	// Clock
	input wire logic        clk,
	// Application word to the sequencer
	output logic     [15:0] command_word
);
	// Reserved ramp bits idle high from time zero
	initial command_word = 16'h0070;

	// New word just after a falling edge, then held until the next send
	task automatic send(input logic [15:0] w);
		@(negedge clk);
		command_word = w | 16'h0070;
	endtask
endmodule // dsm_commander

// file: tb/testbench.sv
`timescale 1ns/1ns

module testbench import dsm_pkg::*;;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [15:0] net_w = 16'h0000;
	logic [15:0] app_w;
	logic [15:0] key_w = 16'h0000;
	dsm_source_t src = DSM_SRC_APP;
	logic        trip = 1'b0;
	logic        fault_on = 1'b0;
	logic        qs_done = 1'b0;
	logic        fr_done = 1'b0;
	logic        line_on = 1'b1;
	logic        stop_done = 1'b0;
	logic        jog;
	logic        rev;
	logic [15:0] eff;
	logic [15:0] sts;
	logic [2:0]  st;
	logic        run;
	logic        net_ref;
	int          bad_count = 0;
	int          cmp_count = 0;

	// Clock at 50 MHz
	always #10 clk = ~clk;

	dsm_commander cmdr (.clk(clk), .command_word(app_w));

	dsm_sequencer uut (.clk(clk), .reset_n(reset_n),
		.network_command_word(net_w), .application_command_word(app_w),
		.local_keypad_word(key_w), .control_source_select(src),
		.init_complete(1'b1), .drive_trip(trip), .fault_present(fault_on),
		.line_supply_present(line_on), .stop_complete(stop_done),
		.shutdown_complete(1'b0), .quick_stop_complete(qs_done),
		.fault_reaction_complete(fr_done), .effective_command_word(eff),
		.sequencer_status_word(sts), .sequencing_state(st),
		.run_enable(run), .jog_select(jog), .reverse_select(rev),
		.network_reference_select(net_ref));

	task chk_state(input logic [2:0] e);
		cmp_count++;
		if (st !== e) begin
			bad_count++;
			$display("ERROR state exp %0d got %0d", e, st);
		end
	endtask

	task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask

	// Word in, then the state two edges later
	task step(input logic [15:0] w, input logic [2:0] e);
		cmdr.send(w);
		repeat (2) @(negedge clk);
		chk_state(e);
	endtask

	task complete_run;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task t_walk;
		step(16'h0006, 3'd2);
		step(16'h0007, 3'd3);
		step(16'h000F, 3'd4);
		chk_word("run", 16'h0001, {15'h0000, run});
		chk_word("status", 16'h0037, sts & 16'h8077);
		step(16'h300F, 3'd4);
		chk_word("jogrev", 16'h0003, {14'h0000, jog, rev});
		step(16'h000B, 3'd5);
		chk_word("status", 16'h8001, sts & 16'h8027);
		qs_done = 1'b1;
		@(negedge clk);
		qs_done = 1'b0;
		chk_state(3'd1);
	endtask

	task t_disable;
		step(16'h0006, 3'd2);
		step(16'h0007, 3'd3);
		step(16'h000F, 3'd4);
		step(16'h0007, 3'd4);
		chk_word("stopping", 16'h8000, sts & 16'h8000);
		stop_done = 1'b1;
		@(negedge clk);
		stop_done = 1'b0;
		chk_state(3'd3);
		step(16'h000F, 3'd4);
		step(16'h000D, 3'd1);
		step(16'h0006, 3'd2);
		step(16'h0007, 3'd3);
		step(16'h0003, 3'd1);
	endtask

	// Level start is refused once the rising edge is demanded
	task t_edge;
		step(16'h4007, 3'd2);
		@(negedge clk);
		chk_state(3'd3);
		step(16'h8007, 3'd3);
		step(16'h800F, 3'd4);
		step(16'h800D, 3'd1);
		step(16'h800E, 3'd2);
		step(16'h800F, 3'd3);
		repeat (3) @(negedge clk);
		chk_state(3'd3);
		step(16'h0005, 3'd1);
	endtask

	task t_fault;
		trip = 1'b1;
		@(negedge clk);
		chk_state(3'd6);
		chk_word("status", 16'h0008, sts & 16'h0008);
		fr_done = 1'b1;
		@(negedge clk);
		fr_done = 1'b0;
		chk_state(3'd7);
		fault_on = 1'b1;
		step(16'h0086, 3'd7);
		fault_on = 1'b0;
		trip = 1'b0;
		step(16'h0006, 3'd7);
		step(16'h0086, 3'd1);
	endtask

	// Network source with application bit 8 set trips the drive
	task t_network;
		cmdr.send(16'h0106);
		src = DSM_SRC_NETWORK;
		net_w = 16'hCC7B;
		repeat (2) @(negedge clk);
		chk_word("command", 16'hCD7A, eff);
		chk_state(3'd6);
		chk_word("status", 16'h4200, sts & 16'h4200);
		chk_word("netref", 16'h0001, {15'h0000, net_ref});
	endtask

	// Keypad word with safety bits from the application
	task t_local;
		cmdr.send(16'h0000);
		src = DSM_SRC_LOCAL;
		key_w = 16'h3208;
		repeat (2) @(negedge clk);
		chk_word("command", 16'h3008, eff);
		chk_word("status", 16'h3000, sts & 16'h3D80);
		chk_state(3'd7);
		line_on = 1'b0;
		@(negedge clk);
		chk_word("supply", 16'h0000, sts & 16'h0010);
	endtask

	initial begin
		repeat (4) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk_state(3'd1);
		t_walk();
		t_disable();
		t_edge();
		t_fault();
		t_network();
		t_local();
		complete_run();
	end

	// Whole run is about a hundred cycles
	initial begin
		#400000;
		bad_count++;
		complete_run();
	end
endmodule // testbench

bind dsm_sequencer dsm_sequencer_sva chk (.clk(clk), .reset_n(reset_n),
	.network_command_word(network_command_word),
	.application_command_word(application_command_word),
	.local_keypad_word(local_keypad_word),
	.control_source_select(control_source_select), .drive_trip(drive_trip),
	.fault_present(fault_present), .quick_stop_complete(quick_stop_complete),
	.fault_reaction_complete(fault_reaction_complete),
	.effective_command_word(effective_command_word),
	.sequencer_status_word(sequencer_status_word),
	.sequencing_state(sequencing_state), .run_enable(run_enable),
	.jog_select(jog_select), .reverse_select(reverse_select));
